// ---- rtl/dsx_core.sv ----
`timescale 1ns/1ps
// How it works
// RULE_01: opcode 0010 11da decrements the file register and skips when the result is zero.
// RULE_02: opcode 0100 11da decrements the file register and skips when the result is nonzero.
// RULE_03: destination bit 0 sends the result to the working register, 1 writes the file back.
// RULE_04: access bit 0 uses the fixed access bank, access bit 1 uses the bank select register.
// RULE_05: a skip discards the fetched next instruction and runs a no_operation instead.
// RULE_06: one word; one cycle, two on a skip, three when the skipped word is two words long.
// RULE_07: the file address is a full eight bits, destination and access are single bits.
// RULE_08: each cycle runs decode, read, decrement, write phases; skipped cycles do nothing.
module dsx_core
    import dsx_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // fetch stage
    input wire logic [15:0] INSN,
    input wire logic INSN_VALID,
    input wire logic INSN_TWO_WORD,
    input wire logic [3:0] BANK_SELECT,
    // data memory
    output dsx_mem_t MEM,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    // status
    output logic [7:0] WREG,
    output logic [3:0] PHASE,
    output logic CYCLE_END,
    output logic SKIPPING,
    output logic INSN_TAKEN
);
    ////////////////////////////////////////////////////////////////
    dsx_dec_t dec;
    dsx_phase_t phase_q, phase_d;
    dsx_dec_t cur_q, cur_d;
    logic [3:0] bank_q, bank_d;
    logic [7:0] data_q, data_d;
    logic [7:0] w_q, w_d;
    logic [1:0] skip_q, skip_d;
    logic pend_q, pend_d;
    dsx_mem_t mem_q, mem_d;
    logic [7:0] wdata_q, wdata_d;

    dsx_decode u_dec (
        .insn(INSN),
        .dec(dec)
    );

    function automatic logic skip_hit(input logic nonzero, input logic [7:0] res);
        // zero test flips for the nonzero form
        skip_hit = nonzero ? (res != 8'h00) : (res == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////
    // address of the file register in the selected bank
    function automatic logic [11:0] file_addr(input logic [3:0] bank, input logic [7:0] faddr);
        file_addr = {bank, faddr};
    endfunction

    // phase sequencer
    always_comb begin
        case (phase_q)
            // RULE_08: four phases per cycle
            DSX_Q1: begin
                phase_d = DSX_Q2;
            end
            DSX_Q2: begin
                phase_d = DSX_Q3;
            end
            DSX_Q3: begin
                phase_d = DSX_Q4;
            end
            DSX_Q4: begin
                phase_d = DSX_Q1;
            end
            default: begin
                phase_d = DSX_Q1;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            phase_q <= DSX_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // instruction latch, loaded in the decode phase
    always_comb begin
        cur_d = cur_q;
        bank_d = bank_q;
        if (phase_q == DSX_Q1) begin
            if (skip_q != 2'h0) begin
                // RULE_05: fetched word replaced by no_operation
                cur_d = '0;
            end else begin
                // RULE_01: skip-on-zero decode
                // RULE_02: skip-on-nonzero decode
                cur_d = INSN_VALID ? dec : '0;
                // RULE_04: access bank or bank select
                bank_d = dec.use_bank ? BANK_SELECT : DSX_ACCESS_BANK;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cur_q <= '0;
            bank_q <= DSX_ACCESS_BANK;
        end else begin
            cur_q <= cur_d;
            bank_q <= bank_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // decrement and destination
    always_comb begin
        data_d = data_q;
        w_d = w_q;
        wdata_d = wdata_q;
        // RULE_08: decrement phase
        if ((phase_q == DSX_Q3) && cur_q.valid) begin
            data_d = MEM_RDATA - 8'h01;
        end
        // RULE_03: destination select
        if ((phase_q == DSX_Q4) && cur_q.valid) begin
            if (cur_q.to_file) begin
                wdata_d = data_q;
            end else begin
                w_d = data_q;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            data_q <= 8'h00;
            w_q <= DSX_RESET_W;
            wdata_q <= 8'h00;
        end else begin
            data_q <= data_d;
            w_q <= w_d;
            wdata_q <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // memory strobes, idle outside their phase
    always_comb begin
        mem_d = '0;
        if (cur_q.valid) begin
            case (phase_q)
                // RULE_08: read phase
                DSX_Q2: begin
                    // RULE_07: full 8-bit file address
                    mem_d.addr = file_addr(bank_q, cur_q.faddr);
                end
                // RULE_08: write phase
                DSX_Q4: begin
                    if (cur_q.to_file) begin
                        mem_d.we = 1'b1;
                        mem_d.addr = file_addr(bank_q, cur_q.faddr);
                    end
                end
                default: begin
                    mem_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mem_q <= '0;
        end else begin
            mem_q <= mem_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // discard counter, one count per no_operation cycle
    always_comb begin
        skip_d = skip_q;
        pend_d = pend_q;
        case (phase_q)
            DSX_Q1: begin
                // RULE_06: victim length known only once fetched
                if (pend_q) begin
                    pend_d = 1'b0;
                    if (INSN_VALID && INSN_TWO_WORD) begin
                        skip_d = 2'h2;
                    end
                end
            end
            DSX_Q4: begin
                if (skip_q != 2'h0) begin
                    // RULE_08: skipped cycle ends
                    skip_d = skip_q - 2'h1;
                end else if (cur_q.valid && skip_hit(cur_q.sel_nonzero, data_q)) begin
                    // RULE_05: arm discard of next word
                    skip_d = 2'h1;
                    pend_d = 1'b1;
                end
            end
            default: begin
                skip_d = skip_q;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            skip_q <= 2'h0;
            pend_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
            pend_q <= pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign MEM = mem_q;
    assign MEM_WDATA = wdata_q;
    assign WREG = w_q;
    assign PHASE = phase_q;
    assign CYCLE_END = (phase_q == DSX_Q4);
    assign SKIPPING = (skip_q != 2'h0);
    assign INSN_TAKEN = (phase_q == DSX_Q1) && (skip_q == 2'h0);
endmodule

// ---- rtl/dsx_pkg.sv ----
package dsx_pkg;

    // opcode layout: [15:10] operation, [9] destination, [8] access, [7:0] file address
    localparam logic [5:0] DSX_OP_SKZ = 6'h0B;
    localparam logic [5:0] DSX_OP_SKNZ = 6'h13;
    localparam int DSX_OP_HI = 15;
    localparam int DSX_OP_LO = 10;
    localparam int DSX_D_BIT = 9;
    localparam int DSX_A_BIT = 8;
    localparam int DSX_F_HI = 7;
    localparam int DSX_F_LO = 0;
    localparam logic [3:0] DSX_ACCESS_BANK = 4'h0;
    localparam logic [7:0] DSX_RESET_W = 8'h00;
    localparam logic [3:0] DSX_RESET_PHASE = 4'h1;
    // phases per instruction cycle
    localparam int DSX_PHASES = 4;

    typedef enum logic [3:0] {
        DSX_Q1 = 4'h1,
        DSX_Q2 = 4'h2,
        DSX_Q3 = 4'h4,
        DSX_Q4 = 4'h8
    } dsx_phase_t;

    typedef struct packed {
        logic valid;
        logic sel_nonzero;
        logic to_file;
        logic use_bank;
        logic [7:0] faddr;
    } dsx_dec_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
    } dsx_mem_t;

endpackage

// ---- rtl/dsx_decode.sv ----
`timescale 1ns/1ps
module dsx_decode
    import dsx_pkg::*;
(
    // instruction word
    input wire logic [15:0] insn,
    // decoded fields
    output dsx_dec_t dec
);
    logic [5:0] op;

    always_comb begin
        op = insn[DSX_OP_HI:DSX_OP_LO];
        dec.valid = (op == DSX_OP_SKZ) || (op == DSX_OP_SKNZ);
        dec.sel_nonzero = (op == DSX_OP_SKNZ);
        dec.to_file = insn[DSX_D_BIT];
        dec.use_bank = insn[DSX_A_BIT];
        dec.faddr = insn[DSX_F_HI:DSX_F_LO];
    end
endmodule

// ---- verif/dsx_core_monitor.sv ----
`timescale 1ns/1ps
module dsx_core_monitor
    import dsx_pkg::*;
(
    // clock, fetch
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [15:0] INSN,
    input wire logic INSN_VALID,
    input wire logic INSN_TWO_WORD,
    input wire logic [3:0] BANK_SELECT,
    // memory, status
    input dsx_mem_t MEM,
    input wire logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    input wire logic [7:0] WREG,
    input wire logic [3:0] PHASE,
    input wire logic CYCLE_END,
    input wire logic SKIPPING,
    input wire logic INSN_TAKEN
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic tk;
    logic op;
    logic two_victim;
    assign op = INSN[15:10] == DSX_OP_SKZ || INSN[15:10] == DSX_OP_SKNZ;
    assign two_victim = INSN_VALID && INSN_TWO_WORD;
    assign tk = INSN_TAKEN && INSN_VALID && !SKIPPING && PHASE[0];
    phase_wrap_a: assert property (PHASE[3] |=> PHASE == 4'h1) else $error("bad wrap");
    end_phase_a: assert property (PHASE[0] |=> ##2 CYCLE_END ##1 !CYCLE_END)
        else $error("bad end");
    read_addr_a: assert property (tk && op |-> ##2 MEM.addr ==
        {$past(INSN[8], 2) ? $past(BANK_SELECT, 2) : DSX_ACCESS_BANK, $past(INSN[7:0], 2)})
        else $error("bad addr");
    to_wreg_a: assert property (tk && op && !INSN[9] |-> ##4 WREG == $past(MEM_RDATA, 2) - 8'h01)
        else $error("bad wreg");
    to_file_a: assert property (tk && op && INSN[9] |-> ##4 MEM.we &&
        MEM_WDATA == $past(MEM_RDATA, 2) - 8'h01) else $error("bad write");
    skip_zero_a: assert property (tk && INSN[15:10] == DSX_OP_SKZ |->
        ##4 SKIPPING == ($past(MEM_RDATA, 2) == 8'h01)) else $error("bad skz");
    skip_nz_a: assert property (tk && INSN[15:10] == DSX_OP_SKNZ |->
        ##4 SKIPPING == ($past(MEM_RDATA, 2) != 8'h01)) else $error("bad sknz");
    refuse_a: assert property (tk && !op |-> ##2 MEM.addr == 12'h000 ##2 !MEM.we)
        else $error("bad refuse");
    skip_quiet_a: assert property (SKIPPING && PHASE[2] |-> MEM.addr == 12'h000)
        else $error("bad skip read");
    skip_hold_a: assert property (SKIPPING && PHASE[0] |-> SKIPPING [*4])
        else $error("bad skip hold");
    skip_no_access_a: assert property (SKIPPING && PHASE[0] |->
        ##2 MEM.addr == 12'h000 ##2 !MEM.we) else $error("bad skip access");
    two_word_skip_a: assert property ($rose(SKIPPING) && PHASE[0] |->
        ##4 SKIPPING == $past(two_victim, 4)) else $error("bad two word skip");
endmodule
bind dsx_core dsx_core_monitor i_dsx_core_monitor (
    .CLOCK(CLOCK),
    .RST(RST),
    .INSN(INSN),
    .INSN_VALID(INSN_VALID),
    .INSN_TWO_WORD(INSN_TWO_WORD),
    .BANK_SELECT(BANK_SELECT),
    .MEM(MEM),
    .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA),
    .WREG(WREG),
    .PHASE(PHASE),
    .CYCLE_END(CYCLE_END),
    .SKIPPING(SKIPPING),
    .INSN_TAKEN(INSN_TAKEN)
);

// ---- verif/dsx_mem_model.sv ----
`timescale 1ns/1ps
module dsx_mem_model
    import dsx_pkg::*;
(
    // core side
    input wire logic clock,
    input dsx_mem_t mem,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] m [4096];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            m[i] = 8'(i * 7);
        end
    end
    assign rdata = m[mem.addr];
    always @(posedge clock) begin
        if (mem.we) begin
            m[mem.addr] <= wdata;
        end
    end
endmodule

// ---- verif/dsx_core_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t mismatch", $time); end end
module dsx_core_tb;
    import dsx_pkg::*;
    logic clock = 0, rst = 1, valid = 0, two = 0;
    logic [15:0] insn = 16'h0000;
    logic [3:0] bsel = 4'h0;
    logic [7:0] wdata, rdata, wreg, wp;
    logic [3:0] phase;
    logic cend, skipping, taken;
    dsx_mem_t mem;
    int num_errors = 0, n_compared = 0;
    dsx_core i_dsx_core (.CLOCK(clock), .RST(rst), .INSN(insn), .INSN_VALID(valid),
        .INSN_TWO_WORD(two), .BANK_SELECT(bsel), .MEM(mem), .MEM_WDATA(wdata),
        .MEM_RDATA(rdata), .WREG(wreg), .PHASE(phase), .CYCLE_END(cend),
        .SKIPPING(skipping), .INSN_TAKEN(taken));
    dsx_mem_model i_dsx_mem_model (.clock(clock), .mem(mem), .wdata(wdata), .rdata(rdata));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] exp_dec(input logic [7:0] v);
        exp_dec = v - 8'h01;
    endfunction
    function automatic logic exp_skip(input logic nz, input logic [7:0] v);
        exp_skip = (exp_dec(v) == 8'h00) ^ nz;
    endfunction
    task automatic run(input logic nz, d, a, input logic [7:0] f, v, input logic [3:0] bs,
        input logic tw);
        logic [11:0] ea;
        logic sk;
        ea = a ? {bs, f} : {DSX_ACCESS_BANK, f};
        sk = exp_skip(nz, v);
        i_dsx_mem_model.m[ea] = v;
        do @(posedge clock); while (phase !== DSX_Q4);
        wp = wreg;
        insn <= {nz ? DSX_OP_SKNZ : DSX_OP_SKZ, d, a, f};
        valid <= 1'b1;
        bsel <= bs;
        two <= 1'b0;
        @(posedge clock);
        insn <= 16'hFFFF;
        two <= tw;
        repeat (3) @(posedge clock);
        #1;
        `CHK(skipping, sk)
        `CHK(taken, !sk)
        `CHK(wreg, d ? wp : exp_dec(v))
        @(posedge clock);
        #1;
        `CHK(i_dsx_mem_model.m[ea], d ? exp_dec(v) : v)
        `CHK(skipping, sk)
        repeat (3) @(posedge clock);
        #1;
        `CHK(skipping, sk & tw)
        `CHK(taken, !(sk & tw))
    endtask
    initial begin
        void'($urandom(66652));
        repeat (19) @(posedge clock);
        #1;
        `CHK(phase, DSX_Q1)
        `CHK(mem, 13'h0000)
        `CHK(wreg, DSX_RESET_W)
        `CHK(skipping, 1'b0)
        @(posedge clock);
        rst <= 1'b0;
        run(1'b0, 1'b1, 1'b0, 8'hFF, 8'h01, 4'h3, 1'b1);
        // reset again while a discard is running
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK(phase, DSX_Q1)
        `CHK(wreg, DSX_RESET_W)
        `CHK(skipping, 1'b0)
        @(posedge clock);
        rst <= 1'b0;
        run(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 4'hF, 1'b0);
        run(1'b0, 1'b0, 1'b1, 8'h80, 8'h05, 4'hA, 1'b1);
        run(1'b1, 1'b1, 1'b0, 8'h7F, 8'h01, 4'h5, 1'b1);
        repeat (60) begin
            run(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom % 3),
                4'($urandom), 1'($urandom));
        end
        stop_test;
    end
    initial begin
        #100000;
        num_errors++;
        stop_test;
    end
endmodule
